// ### logic/cmrs_pkg.sv
// Package of constants for the control-mode, reset and power-status block
package cmrs_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] REG_SOFT_RESET = 7'h09;
  localparam logic [6:0] REG_POWER_CTRL = 7'h0a;
  localparam logic [6:0] REG_CFG_FIRST = 7'h0a;
  localparam logic [6:0] REG_CFG_LAST = 7'h1c;
  localparam int CFG_COUNT = 19;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h55;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  // ==========================================================
  // Field positions in the power control register
  localparam int POS_ENABLE = 7;
  localparam int POS_ACTIVATE = 6;
  localparam int POS_RX_TX = 5;
  localparam int POS_TX_ANTENNA_SWITCH = 3;
  localparam int POS_RX_ANTENNA_SWITCH = 2;
  // ==========================================================
  // Serial frame: command byte then data byte, MSB first
  localparam int POS_RW = 7;
  localparam logic [3:0] BITS_CMD = 4'h8;
  localparam logic [3:0] BITS_FRAME = 4'hf;
  // ==========================================================
  // Configuration load from EEPROM
  localparam logic [7:0] EE_READ_CMD = 8'h03;
  localparam logic [7:0] EE_SET_STRIDE = 8'h20;
  localparam logic [7:0] EE_HEADER_BITS = 8'h10;
  localparam logic [7:0] EE_TOTAL_BITS = 8'ha8;
  localparam int CLK_SYS_NS = 20;
  localparam int EE_HALF_PERIOD_NS = 500;
  localparam int EE_HALF_CYCLES_INT = (EE_HALF_PERIOD_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [7:0] EE_HALF_CYCLES = 8'(EE_HALF_CYCLES_INT);
  // ==========================================================
  // Status encoding
  localparam logic [1:0] ST_BATTERY_SAVING = 2'h0;
  localparam logic [1:0] ST_STANDBY = 2'h1;
  localparam logic [1:0] ST_RUN = 2'h2;
  typedef enum {EE_IDLE, EE_LOAD, EE_DONE} cmrs_ee_e;
endpackage

// ### logic/cmrs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module cmrs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output var logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          o_sync[g] <= 1'b0;
        end else if (i_ce) begin
          s1 <= i_async[g];
          s2 <= s1;
          s3 <= s2;
          // A change only counts once two stages agree
          if (s2 == s3) begin
            o_sync[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### logic/cmrs_top.sv
// Control-mode selection, reset handling and power-status control
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Source pin picks serial or EEPROM mode
// - Test pin picks user test variant
// - Serial mode: slave, MISO returns read data
// - EEPROM mode: master, loads at reset release
// - Set covers 0x0A..0x1C, eight sets
// - Reset low initialises, ignores setting inputs
// - Set-select pins usable during reset
// - Serial mode: Battery Saving after hardware reset
// - Oscillator starts only after reset release
// - Pattern 01010101 at 0x09 resets registers
// - Soft reset ends at clock/select rise
// - Battery Saving after soft reset
// - Soft reset ignored in normal EEPROM mode
// - Soft reset clears registers only
// - Reset command register reads zero
// - Enable pin (serial mode only) and bits select status
// - Battery Saving still accepts writes
// - Standby keeps oscillator, regulators running
// - Transmit/receive only in Run
// - EEPROM test variant is a slave
// - Auto-off keeps enable/activate bits set
// - MISO driven only during reads
module cmrs_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reset_n_pin,
  input wire logic i_control_source_select,
  input wire logic i_test_variant_select,
  input wire logic i_power_enable,
  input wire logic i_auto_off,
  input wire logic i_spi_cs_n,
  output logic o_spi_cs_n,
  output logic o_spi_cs_n_oe,
  input wire logic i_spi_sclk,
  output logic o_spi_sclk,
  output logic o_spi_sclk_oe,
  input wire logic i_spi_mosi,
  output logic o_spi_mosi,
  output logic o_spi_mosi_oe,
  input wire logic i_spi_miso,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  input wire logic i_tx_antenna_switch,
  output logic o_tx_antenna_switch,
  output logic o_tx_antenna_switch_oe,
  input wire logic i_rx_antenna_switch,
  output logic o_rx_antenna_switch,
  output logic o_rx_antenna_switch_oe,
  output logic [1:0] o_status,
  output logic o_crystal_oscillator_en,
  output logic o_analog_regulator_en,
  output logic o_txrx_enable,
  output logic o_eeprom_master,
  output logic o_load_done,
  output logic [2:0] o_config_set
);
  import cmrs_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [8:0] pins;
  cmrs_sync #(.W(9)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_reset_n_pin, i_control_source_select, i_test_variant_select, i_power_enable,
              i_spi_cs_n, i_spi_sclk, i_spi_mosi, i_spi_miso,
              i_tx_antenna_switch | i_rx_antenna_switch & 1'b0}),
    .o_sync(pins)
  );
  // Receive pin is routed separately to keep the bundle readable
  logic rx_antenna_switch_s1;
  logic rx_antenna_switch_s2;
  logic rx_antenna_switch_s3;
  logic rx_antenna_switch_pin;

  wire reset_n = pins[8];
  wire src_pin = pins[7];
  wire test_pin = pins[6];
  wire enable_pin = pins[5];
  wire cs_n = pins[4];
  wire sclk = pins[3];
  wire mosi = pins[2];
  wire miso_in = pins[1];
  wire tx_antenna_switch_pin = pins[0];

  // ==========================================================
  // Straps and edges
  logic mode_eeprom;
  logic mode_test;
  logic reset_n_d;
  logic cs_n_d;
  logic sclk_d;
  wire hw_release = reset_n & ~reset_n_d;
  wire sclk_rise = sclk & ~sclk_d;
  wire sclk_fall = ~sclk & sclk_d;
  wire cs_rise = cs_n & ~cs_n_d;
  wire cs_fall = ~cs_n & cs_n_d;
  wire is_master = mode_eeprom & ~mode_test;
  wire soft_allowed = ~is_master;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_antenna_switch_s1 <= 1'b0;
      rx_antenna_switch_s2 <= 1'b0;
      rx_antenna_switch_s3 <= 1'b0;
      rx_antenna_switch_pin <= 1'b0;
    end else if (i_ce) begin
      rx_antenna_switch_s1 <= i_rx_antenna_switch;
      rx_antenna_switch_s2 <= rx_antenna_switch_s1;
      rx_antenna_switch_s3 <= rx_antenna_switch_s2;
      if (rx_antenna_switch_s2 == rx_antenna_switch_s3) begin
        rx_antenna_switch_pin <= rx_antenna_switch_s3;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_eeprom <= 1'b0;
      mode_test <= 1'b0;
      reset_n_d <= 1'b0;
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
      o_config_set <= 3'h0;
    end else if (i_ce) begin
      reset_n_d <= reset_n;
      cs_n_d <= cs_n;
      sclk_d <= sclk;
      // Straps follow the pins only while reset is held
      if (!reset_n) begin
        mode_eeprom <= src_pin;
        mode_test <= test_pin;
        o_config_set <= {enable_pin, tx_antenna_switch_pin, rx_antenna_switch_pin};
      end
    end
  end

  // ==========================================================
  // Register file
  logic [7:0] regs [CFG_COUNT];
  logic soft_reset_active;
  logic ee_we;
  logic [4:0] ee_idx;
  logic [7:0] ee_byte;
  logic spi_we;
  logic [6:0] spi_addr;
  logic [7:0] spi_wdata;

  function automatic logic cfg_hit(input logic [6:0] a);
    cfg_hit = (a >= REG_CFG_FIRST) && (a <= REG_CFG_LAST);
  endfunction

  wire [4:0] spi_idx = 5'(spi_addr - REG_CFG_FIRST);
  wire soft_cmd = spi_we && spi_addr == REG_SOFT_RESET && spi_wdata == SOFT_RESET_CODE;
  wire soft_start = soft_cmd & soft_allowed;
  wire [7:0] power_reg = regs[0];
  wire bit_enable = power_reg[POS_ENABLE];
  wire bit_activate = power_reg[POS_ACTIVATE];

  genvar g;
  generate
    for (g = 0; g < CFG_COUNT; g++) begin : g_reg
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          regs[g] <= REG_RESET_VALUE;
        end else if (i_ce) begin
          if (!reset_n || soft_start || soft_reset_active) begin
            regs[g] <= REG_RESET_VALUE;
          end else if (ee_we && ee_idx == 5'(g)) begin
            regs[g] <= ee_byte;
          end else if (spi_we && cfg_hit(spi_addr) && spi_idx == 5'(g)) begin
            regs[g] <= spi_wdata;
          end
        end
      end
    end
  endgenerate

  // Soft reset is held until the first rising clock or select edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      soft_reset_active <= 1'b0;
    end else if (i_ce) begin
      // A new command in the same cycle as a release edge wins
      if (soft_start) begin
        soft_reset_active <= 1'b1;
      end else if (!reset_n || sclk_rise || cs_rise) begin
        soft_reset_active <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Serial slave: command byte (rw, address) then data byte
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic frame_read;
  wire slave_on = reset_n & ~is_master & ~cs_n;
  wire [7:0] next_shift = {shift_in[6:0], mosi};
  wire [6:0] rd_addr = next_shift[6:0];
  wire [4:0] rd_idx = 5'(rd_addr - REG_CFG_FIRST);
  // Reset command register and unmapped addresses read as zero
  wire [7:0] rd_data = cfg_hit(rd_addr) ? regs[rd_idx] : 8'h00;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      frame_read <= 1'b0;
      spi_we <= 1'b0;
      spi_addr <= 7'h00;
      spi_wdata <= 8'h00;
    end else if (i_ce) begin
      spi_we <= 1'b0;
      if (!slave_on || cs_fall) begin
        bit_cnt <= 4'h0;
        if (!slave_on) begin
          frame_read <= 1'b0;
        end
      end else if (sclk_rise) begin
        shift_in <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == BITS_CMD - 4'h1) begin
          frame_read <= next_shift[POS_RW];
          spi_addr <= rd_addr;
          shift_out <= rd_data;
        end else if (bit_cnt == BITS_FRAME) begin
          spi_we <= ~frame_read;
          spi_wdata <= next_shift;
        end
      end else if (sclk_fall && frame_read && bit_cnt > BITS_CMD) begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // EEPROM configuration loader
  cmrs_ee_e ee_state;
  logic [7:0] div_cnt;
  logic [7:0] ee_bits;
  logic [15:0] ee_header;
  logic ee_sclk;
  logic osc_on;
  wire ee_tick = div_cnt == EE_HALF_CYCLES - 8'h1;
  wire [7:0] set_addr = 8'(o_config_set * EE_SET_STRIDE);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ee_state <= EE_IDLE;
      div_cnt <= 8'h00;
      ee_bits <= 8'h00;
      ee_header <= 16'h0000;
      ee_sclk <= 1'b0;
      ee_we <= 1'b0;
      ee_idx <= 5'h00;
      ee_byte <= 8'h00;
      osc_on <= 1'b0;
    end else if (i_ce) begin
      ee_we <= 1'b0;
      if (!reset_n || !is_master) begin
        ee_state <= EE_IDLE;
        ee_sclk <= 1'b0;
        osc_on <= 1'b0;
        div_cnt <= 8'h00;
      end else begin
        case (ee_state)
          EE_IDLE: begin
            if (hw_release) begin
              ee_state <= EE_LOAD;
              osc_on <= 1'b1;
              ee_bits <= 8'h00;
              ee_idx <= 5'h00;
              ee_header <= {EE_READ_CMD, set_addr};
            end
          end
          EE_LOAD: begin
            div_cnt <= ee_tick ? 8'h00 : div_cnt + 8'h1;
            if (ee_tick) begin
              ee_sclk <= ~ee_sclk;
              if (ee_sclk) begin
                // Falling edge: advance the outgoing header
                ee_header <= {ee_header[14:0], 1'b0};
                ee_bits <= ee_bits + 8'h1;
                if (ee_bits == EE_TOTAL_BITS - 8'h1) begin
                  ee_state <= EE_DONE;
                end
              end else if (ee_bits >= EE_HEADER_BITS) begin
                ee_byte <= {ee_byte[6:0], miso_in};
                if (ee_bits[2:0] == 3'h7) begin
                  ee_we <= 1'b1;
                  ee_idx <= 5'(8'(ee_bits - EE_HEADER_BITS) >> 3);
                end
              end
            end
          end
          EE_DONE: begin
            osc_on <= 1'b0;
          end
          default: ee_state <= EE_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Status decode
  wire serial_gate = mode_eeprom | enable_pin;
  wire saving = !reset_n || soft_reset_active || i_auto_off || !serial_gate || !bit_enable;
  wire [1:0] next_status = saving ? ST_BATTERY_SAVING : (bit_activate ? ST_RUN : ST_STANDBY);
  wire awake = next_status != ST_BATTERY_SAVING;
  wire drive_sw = ~mode_eeprom & awake;

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_status <= ST_BATTERY_SAVING;
      o_crystal_oscillator_en <= 1'b0;
      o_analog_regulator_en <= 1'b0;
      o_txrx_enable <= 1'b0;
      o_eeprom_master <= 1'b0;
      o_load_done <= 1'b0;
      o_spi_cs_n <= 1'b1;
      o_spi_cs_n_oe <= 1'b0;
      o_spi_sclk <= 1'b0;
      o_spi_sclk_oe <= 1'b0;
      o_spi_mosi <= 1'b0;
      o_spi_mosi_oe <= 1'b0;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
      o_tx_antenna_switch <= 1'b0;
      o_tx_antenna_switch_oe <= 1'b0;
      o_rx_antenna_switch <= 1'b0;
      o_rx_antenna_switch_oe <= 1'b0;
    end else if (i_ce) begin
      o_status <= next_status;
      o_crystal_oscillator_en <= awake | osc_on;
      o_analog_regulator_en <= awake;
      o_txrx_enable <= next_status == ST_RUN;
      o_eeprom_master <= is_master;
      o_load_done <= ee_state == EE_DONE;
      // Master pins idle high/low/low when not loading
      o_spi_cs_n <= ee_state != EE_LOAD;
      o_spi_cs_n_oe <= is_master;
      o_spi_sclk <= ee_sclk;
      o_spi_sclk_oe <= is_master;
      o_spi_mosi <= ee_state == EE_LOAD && ee_header[15];
      o_spi_mosi_oe <= is_master;
      o_spi_miso <= shift_out[7];
      o_spi_miso_oe <= slave_on & frame_read & (bit_cnt >= BITS_CMD);
      o_tx_antenna_switch <= drive_sw & power_reg[POS_TX_ANTENNA_SWITCH];
      o_tx_antenna_switch_oe <= drive_sw;
      o_rx_antenna_switch <= drive_sw & power_reg[POS_RX_ANTENNA_SWITCH];
      o_rx_antenna_switch_oe <= drive_sw;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cmrs_top_asserts.sv
// Concurrent checks on the ports of the control-mode, reset and status block
`timescale 1ns/10ps
`default_nettype none
module cmrs_top_asserts
  import cmrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_n_pin,
  input wire logic i_control_source_select,
  input wire logic i_test_variant_select,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_cs_n,
  input wire logic o_spi_cs_n_oe,
  input wire logic o_spi_sclk_oe,
  input wire logic o_spi_miso_oe,
  input wire logic o_tx_antenna_switch_oe,
  input wire logic o_rx_antenna_switch_oe,
  input wire logic [1:0] o_status,
  input wire logic o_crystal_oscillator_en,
  input wire logic o_analog_regulator_en,
  input wire logic o_txrx_enable,
  input wire logic o_eeprom_master,
  input wire logic o_load_done
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Status outputs
  txrx_run_only_a: assert property (o_txrx_enable |-> o_status == ST_RUN)
    else $error("txrx enabled outside run");
  regulator_status_a: assert property (o_analog_regulator_en == (o_status != ST_BATTERY_SAVING))
    else $error("regulator enable disagrees with status");
  crystal_oscillator_awake_a: assert property (o_status != ST_BATTERY_SAVING |-> o_crystal_oscillator_en)
    else $error("oscillator off while awake");
  reset_pin_bs_a: assert property (!i_reset_n_pin [*8] |=> o_status == ST_BATTERY_SAVING && !o_crystal_oscillator_en)
    else $error("not asleep while reset pin low");
  // ==========================================================
  // Pin roles; two cycles allowed because enables may lag the mode flag
  miso_idle_a: assert property (i_spi_cs_n [*8] |-> !o_spi_miso_oe)
    else $error("miso driven while deselected");
  master_drives_a: assert property (o_eeprom_master [*2] |-> o_spi_cs_n_oe && o_spi_sclk_oe
    && !o_tx_antenna_switch_oe && !o_rx_antenna_switch_oe)
    else $error("master pin roles wrong");
  slave_quiet_a: assert property (!o_eeprom_master [*2] |-> !o_spi_cs_n_oe && !o_spi_sclk_oe)
    else $error("slave drives select or clock");
  test_slave_a: assert property (i_test_variant_select [*8] |=> !o_eeprom_master)
    else $error("test variant acts as master");
  serial_slave_a: assert property (!i_control_source_select [*8] |=> !o_eeprom_master)
    else $error("serial mode acts as master");
  done_cs_high_a: assert property (o_load_done && o_eeprom_master |-> o_spi_cs_n && o_spi_cs_n_oe)
    else $error("select not released after load");
endmodule
`default_nettype wire

// ### testbench/cmrs_eeprom_model.sv
// Behavioural serial EEPROM answering one sequential read
`timescale 1ns/10ps
`default_nettype none
module cmrs_eeprom_model (
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic [7:0] o_cmd,
  output logic [7:0] o_addr
);
  logic [15:0] hdr;
  logic [7:0] cnt;
  logic [7:0] byt;
  initial begin
    {o_miso, o_cmd, o_addr, hdr, cnt, byt} = '0;
  end
  // ==========================================================
  // Header: read code then set base address, MSB first
  always @(negedge i_cs_n) cnt = 8'h00;
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      hdr = (cnt < 8'h10) ? {hdr[14:0], i_mosi} : hdr;
      cnt = cnt + 8'h01;
      o_cmd = hdr[15:8];
      o_addr = hdr[7:0];
    end
  end
  // ==========================================================
  // Data moves on the falling clock so it is stable at the master's rising sample
  always @(negedge i_sclk) begin
    if (!i_cs_n && cnt >= 8'h10) begin
      byt = o_addr + ((cnt - 8'h10) >> 3);
      byt = (byt[4:0] == 5'h00) ? 8'hc0 : byt;
      o_miso = byt[3'h7 - cnt[2:0]];
    end
  end
  // A released line shows the inverse of its last bit, never a held value
  always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule
`default_nettype wire

// ### testbench/tb_cmrs_top.sv
// Self-checking bench for the control-mode, reset and status block
`timescale 1ns/10ps
`default_nettype none
module tb_cmrs_top;
  import cmrs_pkg::*;
  logic i_clk_sys, i_rst, i_ce, i_reset_n_pin, i_control_source_select, i_test_variant_select;
  logic i_power_enable, i_auto_off, h_cs, h_sclk, h_mosi, h_tx, h_rx, ee_miso;
  logic o_spi_cs_n, o_spi_cs_n_oe, o_spi_sclk, o_spi_sclk_oe, o_spi_mosi, o_spi_mosi_oe, o_spi_miso;
  logic o_spi_miso_oe, o_tx_antenna_switch, o_tx_antenna_switch_oe, o_rx_antenna_switch, o_rx_antenna_switch_oe;
  logic o_crystal_oscillator_en, o_analog_regulator_en, o_txrx_enable, o_eeprom_master, o_load_done;
  logic [1:0] o_status;
  logic [2:0] o_config_set;
  logic [7:0] ee_cmd, ee_addr, rv;
  int fail_count = 0;
  int checked = 0;
  // ==========================================================
  // Wire levels resolved from the DUT's output enables; host and EEPROM drive otherwise
  wire logic i_spi_cs_n = o_spi_cs_n_oe ? o_spi_cs_n : h_cs;
  wire logic i_spi_sclk = o_spi_sclk_oe ? o_spi_sclk : h_sclk;
  wire logic i_spi_mosi = o_spi_mosi_oe ? o_spi_mosi : h_mosi;
  wire logic i_spi_miso = o_spi_miso_oe ? o_spi_miso : ee_miso;
  wire logic i_tx_antenna_switch = o_tx_antenna_switch_oe ? o_tx_antenna_switch : h_tx;
  wire logic i_rx_antenna_switch = o_rx_antenna_switch_oe ? o_rx_antenna_switch : h_rx;
  cmrs_top uut (.*);
  cmrs_eeprom_model u_ee (.i_cs_n(i_spi_cs_n), .i_sclk(i_spi_sclk), .i_mosi(i_spi_mosi),
    .o_miso(ee_miso), .o_cmd(ee_cmd), .o_addr(ee_addr));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // ==========================================================
  // Shared tasks
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Host frame with a 160 ns link clock; MISO sampled late in the high phase to absorb sync delay
  task automatic spi(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] sh;
    sh = {c, d};
    rv = 8'h00;
    h_cs = 1'b0;
    cyc(4);
    for (int i = 0; i < 16; i++) begin
      h_mosi = sh[15-i];
      cyc(4);
      h_sclk = 1'b1;
      cyc(4);
      if (i > 7) rv = {rv[6:0], o_spi_miso};
      if (i == 8 && c[7]) chk("miso_oe", 8'(o_spi_miso_oe), 8'h01);
      h_sclk = 1'b0;
    end
    cyc(4);
    h_cs = 1'b1;
    h_mosi = ~h_mosi;
    cyc(12);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi({1'b0, a}, d);
  endtask
  task automatic rd(input logic [6:0] a);
    spi({1'b1, a}, 8'h00);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_status();
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
    chk("master", 8'(o_eeprom_master), 8'h00);
    i_power_enable = 1'b1;
    wr(REG_POWER_CTRL, 8'hc0);
    chk("status", 8'(o_status), 8'(ST_RUN));
    chk("txrx", 8'(o_txrx_enable), 8'h01);
    rd(REG_POWER_CTRL);
    chk("rd_0a", rv, 8'hc0);
    wr(REG_POWER_CTRL, 8'h80);
    chk("status", 8'(o_status), 8'(ST_STANDBY));
    chk("awake", 8'({o_crystal_oscillator_en, o_analog_regulator_en, o_txrx_enable}), 8'h06);
    i_power_enable = 1'b0;
    cyc(12);
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
    wr(REG_POWER_CTRL, 8'h8c);
    i_power_enable = 1'b1;
    cyc(12);
    chk("status", 8'(o_status), 8'(ST_STANDBY));
    chk("ant", 8'({o_tx_antenna_switch_oe, o_tx_antenna_switch, o_rx_antenna_switch}), 8'h07);
  endtask
  task automatic t_autooff();
    wr(REG_POWER_CTRL, 8'hc0);
    i_auto_off = 1'b1;
    cyc(4);
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
    rd(REG_POWER_CTRL);
    chk("rd_0a", rv, 8'hc0);
    i_auto_off = 1'b0;
    cyc(4);
  endtask
  task automatic t_soft();
    wr(REG_SOFT_RESET, 8'h54);
    chk("status", 8'(o_status), 8'(ST_RUN));
    rd(REG_SOFT_RESET);
    chk("rd_09", rv, 8'h00);
    rd(7'h7f);
    chk("rd_free", rv, 8'h00);
    wr(REG_SOFT_RESET, SOFT_RESET_CODE);
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
    rd(REG_POWER_CTRL);
    chk("rd_0a", rv, REG_RESET_VALUE);
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
  endtask
  task automatic t_eeprom();
    int n;
    i_reset_n_pin = 1'b0;
    i_control_source_select = 1'b1;
    h_rx = 1'b1;
    cyc(12);
    chk("set", 8'(o_config_set), 8'h05);
    chk("idle", 8'({o_spi_cs_n, o_spi_cs_n_oe, o_crystal_oscillator_en, o_spi_sclk_oe, o_spi_mosi_oe,
      o_spi_sclk, o_spi_mosi}), 8'h6c);
    i_reset_n_pin = 1'b1;
    cyc(12);
    chk("crystal_oscillator", 8'(o_crystal_oscillator_en), 8'h01);
    n = 0;
    while (o_load_done !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      $display("Error load_done expected 1 seen timeout");
      final_report();
    end
    chk("ee_cmd", ee_cmd, EE_READ_CMD);
    chk("ee_addr", ee_addr, 8'h05 * EE_SET_STRIDE);
    chk("status", 8'(o_status), 8'(ST_RUN));
    chk("master", 8'(o_eeprom_master), 8'h01);
  endtask
  task automatic t_test();
    i_reset_n_pin = 1'b0;
    i_test_variant_select = 1'b1;
    cyc(12);
    i_reset_n_pin = 1'b1;
    cyc(12);
    chk("master", 8'(o_eeprom_master), 8'h00);
    wr(REG_POWER_CTRL, 8'hc0);
    chk("status", 8'(o_status), 8'(ST_RUN));
    wr(REG_SOFT_RESET, SOFT_RESET_CODE);
    chk("status", 8'(o_status), 8'(ST_BATTERY_SAVING));
  endtask
  initial begin
    {i_rst, i_ce, i_reset_n_pin, h_cs} = 4'hd;
    {i_control_source_select, i_test_variant_select, i_power_enable, i_auto_off} = 4'h0;
    {h_sclk, h_mosi, h_tx, h_rx} = 4'h0;
    cyc(5);
    i_rst = 1'b0;
    // Reset pin held low well over a microsecond after start-up
    cyc(60);
    i_reset_n_pin = 1'b1;
    cyc(10);
    t_status();
    t_autooff();
    t_soft();
    t_eeprom();
    t_test();
    final_report();
  end
endmodule
bind cmrs_top cmrs_top_asserts u_chk (.*);
`default_nettype wire
